// ==== core/ucr_defs.svh ====
// register indices, reset values and field positions of the channel bank
`ifndef UCR_DEFS_SVH
`define UCR_DEFS_SVH

// word index inside one channel, byte address is four times it
`define UCR_IDX_DIV_HIGH   4'h0
`define UCR_IDX_DIV_LOW    4'h1
`define UCR_IDX_DIV_FRAC   4'h2
`define UCR_IDX_HOLDING    4'h3
`define UCR_IDX_INT_EN     4'h4
`define UCR_IDX_FIFO_ISR   4'h5
`define UCR_IDX_LINE_CTL   4'h6
`define UCR_IDX_MODEM_CTL  4'h7
`define UCR_IDX_LINE_STAT  4'h8
`define UCR_IDX_MODEM_STAT 4'h9
`define UCR_IDX_SCRATCH    4'hA
`define UCR_IDX_ENH_FEAT   4'hB
`define UCR_IDX_RESUME1    4'hC
`define UCR_IDX_RESUME2    4'hD
`define UCR_IDX_PAUSE1     4'hE
`define UCR_IDX_PAUSE2     4'hF

// byte address fields
`define UCR_ADR_IDX_HI     5
`define UCR_ADR_IDX_LO     2
`define UCR_ADR_CH_BIT     6
`define UCR_ADR_TOP_HI     31
`define UCR_ADR_TOP_LO     7

// reset values
`define UCR_RST_ZERO       8'h00
`define UCR_RST_DIV_HIGH   8'h00
`define UCR_RST_DIV_LOW    8'h01
`define UCR_RST_SCRATCH    8'hFF

// interrupt status codes
`define UCR_ISR_NONE       8'h01
`define UCR_ISR_TX_EMPTY   8'h02
`define UCR_ISR_RX_DATA    8'h04

// enhanced bits latched by the enhanced enable
`define UCR_ENH_IE_MASK    8'hF0
`define UCR_ENH_FCR_MASK   8'h30
`define UCR_ENH_MCR_MASK   8'hE0
`define UCR_EFR_ENH_BIT    4

// field positions
`define UCR_MCR_DTR_BIT    0
`define UCR_MCR_RTS_BIT    1
`define UCR_MCR_OP2_BIT    3
`define UCR_LCR_BREAK_BIT  6
`define UCR_IER_RX_BIT     0
`define UCR_IER_TX_BIT     1
`define UCR_FCR_EN_BIT     0
`define UCR_LSR_DR_BIT     0
`define UCR_LSR_THRE_BIT   5
`define UCR_LSR_TEMT_BIT   6
`define UCR_ISR_IDLE_BIT   0
`define UCR_ISR_FEN_HI     7
`define UCR_ISR_FEN_LO     6
`define UCR_SEL_DATA_BIT   0

`endif

// ==== core/ucr_pkg.sv ====
// types shared by the channel reset-state register bank
`default_nettype none
package ucr_pkg;

  typedef struct packed {
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [7:0] div_frac;
    logic [7:0] tx_hold;
    logic [7:0] rx_hold;
    logic [7:0] int_en;
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] scratch;
    logic [7:0] enh_feat;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic       rx_ready;
    logic       tx_pend;
    logic [3:0] msr_delta;
    logic [3:0] msr_prev;
  } ucr_chan_s;

  // per-channel link side inputs, modem inputs active low
  typedef struct packed {
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_done;
    logic       cd_n;
    logic       ri_n;
    logic       dsr_n;
    logic       cts_n;
  } ucr_link_s;

  typedef struct packed {
    logic tx;
    logic general_output_two_n;
    logic rts_n;
    logic dtr_n;
    logic receive_ready_n;
    logic transmit_ready_n;
    logic irq;
    logic irq_oe;
  } ucr_pins_s;

endpackage : ucr_pkg
`default_nettype wire

// ==== core/ucr_reset_bank.sv ====
// two-channel uart register bank with its reset state and wishbone slave
// Behaviour
// - power-up loads divisor high with 0x00 and divisor low with 0x01.
// - hardware reset leaves both integer divisor bytes unchanged.
// - reset clears fraction, int enable, fifo, line, modem, enhanced regs.
// - reset clears both resume and both pause characters.
// - interrupt status reads 0x01, nothing pending, after reset.
// - line status reads 0x60 after reset: transmitter empty, no data.
// - scratch register reads 0xFF after reset.
// - reset clears modem change bits; high bits show inverted inputs.
// - holding registers keep their value on hardware reset; power-up clears them.
// - reset holds tx, op2, rts, dtr, rx-ready high; tx-ready low.
// - interrupt pin is not driven during and after reset.
// - four readable writable flow control character registers.
// - reset clears latched enhanced bits of ier, fcr, mcr, fraction.
`timescale 1ns/1ps
`default_nettype none
`include "ucr_defs.svh"

module ucr_reset_bank #(
  parameter int NUM_CH = 2                        // channels in the bank
) (
  input  wire logic                       clk_i,  // 40 MHz clock
  input  wire logic                       rst_i,  // hardware reset, sync
  input  wire logic                       por_i,  // power-up reset, sync
  input  wire logic                       cyc_i,  // wishbone cycle
  input  wire logic                       stb_i,  // wishbone strobe
  input  wire logic                       we_i,   // wishbone write
  input  wire logic [31:0]                adr_i,  // wishbone byte address
  input  wire logic [3:0]                 sel_i,  // wishbone byte enables
  input  wire logic [31:0]                dat_i,  // wishbone write data
  output logic      [31:0]                dat_o,  // wishbone read data
  output logic                            ack_o,  // wishbone acknowledge
  input  wire ucr_pkg::ucr_link_s [NUM_CH-1:0] link_i, // link inputs
  output ucr_pkg::ucr_pins_s [NUM_CH-1:0] pins_o  // channel output pins
);

  ucr_pkg::ucr_chan_s [NUM_CH-1:0] regs_q;
  ucr_pkg::ucr_chan_s [NUM_CH-1:0] regs_d;
  logic                            ack_q;
  logic                            ack_d;
  logic [31:0]                     rdat_q;
  logic [31:0]                     rdat_d;

  // inverted modem input levels, bits cd, ri, dsr, cts
  function automatic logic [3:0] modem_levels(input ucr_pkg::ucr_link_s l);
    modem_levels = ~{l.cd_n, l.ri_n, l.dsr_n, l.cts_n};
  endfunction : modem_levels

  // reset image of one channel; the divisor is kept unless powering up
  function automatic ucr_pkg::ucr_chan_s chan_reset(
    input ucr_pkg::ucr_chan_s c,
    input ucr_pkg::ucr_link_s l,
    input logic               power_up
  );
    ucr_pkg::ucr_chan_s r;
    r = c;
    if (power_up) begin
      r.div_high = `UCR_RST_DIV_HIGH;
      r.div_low  = `UCR_RST_DIV_LOW;
      r.tx_hold  = `UCR_RST_ZERO;
      r.rx_hold  = `UCR_RST_ZERO;
    end
    r.div_frac  = `UCR_RST_ZERO;
    r.int_en    = `UCR_RST_ZERO;
    r.fifo_ctl  = `UCR_RST_ZERO;
    r.line_ctl  = `UCR_RST_ZERO;
    r.modem_ctl = `UCR_RST_ZERO;
    r.enh_feat  = `UCR_RST_ZERO;
    r.resume1   = `UCR_RST_ZERO;
    r.resume2   = `UCR_RST_ZERO;
    r.pause1    = `UCR_RST_ZERO;
    r.pause2    = `UCR_RST_ZERO;
    r.scratch   = `UCR_RST_SCRATCH;
    r.rx_ready  = 1'b0;
    r.tx_pend   = 1'b0;
    r.msr_delta = 4'h0;
    // sampling the live levels avoids a false change flag after release
    r.msr_prev  = modem_levels(l);
    chan_reset = r;
  endfunction : chan_reset

  // enhanced bits only move while the enhanced enable is set
  function automatic logic [7:0] merge_enh(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] enh_mask,
    input logic       enh_en
  );
    merge_enh = enh_en ? new_v : ((old_v & enh_mask) | (new_v & ~enh_mask));
  endfunction : merge_enh

  function automatic logic [7:0] isr_value(input ucr_pkg::ucr_chan_s c);
    logic [7:0] v;
    v = `UCR_ISR_NONE;
    if (c.int_en[`UCR_IER_RX_BIT] && c.rx_ready) begin
      v = `UCR_ISR_RX_DATA;
    end else if (c.int_en[`UCR_IER_TX_BIT] && !c.tx_pend) begin
      v = `UCR_ISR_TX_EMPTY;
    end
    // fifo enable shows in both top status bits
    v[`UCR_ISR_FEN_HI:`UCR_ISR_FEN_LO] = {2{c.fifo_ctl[`UCR_FCR_EN_BIT]}};
    isr_value = v;
  endfunction : isr_value

  function automatic logic [7:0] lsr_value(input ucr_pkg::ucr_chan_s c);
    logic [7:0] v;
    v = `UCR_RST_ZERO;
    v[`UCR_LSR_DR_BIT]   = c.rx_ready;
    v[`UCR_LSR_THRE_BIT] = !c.tx_pend;
    v[`UCR_LSR_TEMT_BIT] = !c.tx_pend;
    lsr_value = v;
  endfunction : lsr_value

  function automatic logic [7:0] read_value(
    input ucr_pkg::ucr_chan_s c,
    input ucr_pkg::ucr_link_s l,
    input logic [3:0]         idx
  );
    logic [7:0] v;
    v = `UCR_RST_ZERO;
    if (idx == `UCR_IDX_DIV_HIGH) begin
      v = c.div_high;
    end else if (idx == `UCR_IDX_DIV_LOW) begin
      v = c.div_low;
    end else if (idx == `UCR_IDX_DIV_FRAC) begin
      v = c.div_frac;
    end else if (idx == `UCR_IDX_HOLDING) begin
      v = c.rx_hold;
    end else if (idx == `UCR_IDX_INT_EN) begin
      v = c.int_en;
    end else if (idx == `UCR_IDX_FIFO_ISR) begin
      v = isr_value(c);
    end else if (idx == `UCR_IDX_LINE_CTL) begin
      v = c.line_ctl;
    end else if (idx == `UCR_IDX_MODEM_CTL) begin
      v = c.modem_ctl;
    end else if (idx == `UCR_IDX_LINE_STAT) begin
      v = lsr_value(c);
    end else if (idx == `UCR_IDX_MODEM_STAT) begin
      v = {modem_levels(l), c.msr_delta};
    end else if (idx == `UCR_IDX_SCRATCH) begin
      v = c.scratch;
    end else if (idx == `UCR_IDX_ENH_FEAT) begin
      v = c.enh_feat;
    end else if (idx == `UCR_IDX_RESUME1) begin
      v = c.resume1;
    end else if (idx == `UCR_IDX_RESUME2) begin
      v = c.resume2;
    end else if (idx == `UCR_IDX_PAUSE1) begin
      v = c.pause1;
    end else begin
      v = c.pause2;
    end
    read_value = v;
  endfunction : read_value

  function automatic ucr_pkg::ucr_chan_s write_value(
    input ucr_pkg::ucr_chan_s c,
    input logic [3:0]         idx,
    input logic [7:0]         wd
  );
    ucr_pkg::ucr_chan_s r;
    logic               enh;
    r   = c;
    enh = c.enh_feat[`UCR_EFR_ENH_BIT];
    if (idx == `UCR_IDX_DIV_HIGH) begin
      r.div_high = wd;
    end else if (idx == `UCR_IDX_DIV_LOW) begin
      r.div_low = wd;
    end else if (idx == `UCR_IDX_DIV_FRAC) begin
      if (enh) begin
        r.div_frac = wd;
      end
    end else if (idx == `UCR_IDX_HOLDING) begin
      r.tx_hold = wd;
      r.tx_pend = 1'b1;
    end else if (idx == `UCR_IDX_INT_EN) begin
      r.int_en = merge_enh(c.int_en, wd, `UCR_ENH_IE_MASK, enh);
    end else if (idx == `UCR_IDX_FIFO_ISR) begin
      r.fifo_ctl = merge_enh(c.fifo_ctl, wd, `UCR_ENH_FCR_MASK, enh);
    end else if (idx == `UCR_IDX_LINE_CTL) begin
      r.line_ctl = wd;
    end else if (idx == `UCR_IDX_MODEM_CTL) begin
      r.modem_ctl = merge_enh(c.modem_ctl, wd, `UCR_ENH_MCR_MASK, enh);
    end else if (idx == `UCR_IDX_SCRATCH) begin
      r.scratch = wd;
    end else if (idx == `UCR_IDX_ENH_FEAT) begin
      r.enh_feat = wd;
    end else if (idx == `UCR_IDX_RESUME1) begin
      r.resume1 = wd;
    end else if (idx == `UCR_IDX_RESUME2) begin
      r.resume2 = wd;
    end else if (idx == `UCR_IDX_PAUSE1) begin
      r.pause1 = wd;
    end else if (idx == `UCR_IDX_PAUSE2) begin
      r.pause2 = wd;
    end
    write_value = r;
  endfunction : write_value

  logic [3:0] acc_idx;
  logic       acc_ch;
  logic       acc_ok;
  logic       any_rst;

  // either reset source puts the whole bank into its reset image
  assign any_rst = rst_i || por_i;

  assign acc_idx = adr_i[`UCR_ADR_IDX_HI:`UCR_ADR_IDX_LO];
  assign acc_ch  = adr_i[`UCR_ADR_CH_BIT];
  // anything past the last channel is unmapped: acked, reads zero
  assign acc_ok  = (adr_i[`UCR_ADR_TOP_HI:`UCR_ADR_TOP_LO] == 25'h0000000)
                   && (32'(acc_ch) < 32'(NUM_CH));

  always_comb begin
    logic [3:0] lvl;
    lvl    = 4'h0;
    regs_d = regs_q;
    ack_d  = cyc_i && stb_i && !ack_q;
    rdat_d = 32'h00000000;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      lvl = modem_levels(link_i[ch]);
      if (link_i[ch].tx_done) begin
        regs_d[ch].tx_pend = 1'b0;
      end
      if (ack_d && acc_ok && (32'(acc_ch) == ch)) begin
        if (we_i) begin
          if (sel_i[`UCR_SEL_DATA_BIT]) begin
            regs_d[ch] = write_value(regs_d[ch], acc_idx, dat_i[7:0]);
          end
        end else begin
          rdat_d = {24'h000000, read_value(regs_q[ch], link_i[ch], acc_idx)};
          // read side effects clear first so a same-cycle event survives
          if (acc_idx == `UCR_IDX_HOLDING) begin
            regs_d[ch].rx_ready = 1'b0;
          end
          if (acc_idx == `UCR_IDX_MODEM_STAT) begin
            regs_d[ch].msr_delta = 4'h0;
          end
        end
      end
      if (link_i[ch].rx_valid) begin
        regs_d[ch].rx_hold  = link_i[ch].rx_data;
        regs_d[ch].rx_ready = 1'b1;
      end
      regs_d[ch].msr_delta = regs_d[ch].msr_delta | (lvl ^ regs_q[ch].msr_prev);
      regs_d[ch].msr_prev  = lvl;
      if (any_rst) begin
        // each channel takes the same image from its own state
        regs_d[ch] = chan_reset(regs_q[ch], link_i[ch], por_i);
      end
    end
    // reset wins over a bus access seen in the same cycle
    if (any_rst) begin
      ack_d  = 1'b0;
      rdat_d = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    regs_q <= regs_d;
    ack_q  <= ack_d;
    rdat_q <= rdat_d;
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // reset overrides the pins without waiting for a clock edge
  always_comb begin
    logic [7:0] isr_v;
    isr_v  = `UCR_ISR_NONE;
    pins_o = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (rst_i || por_i) begin
        pins_o[ch].tx                   = 1'b1;
        pins_o[ch].general_output_two_n = 1'b1;
        pins_o[ch].rts_n                = 1'b1;
        pins_o[ch].dtr_n                = 1'b1;
        pins_o[ch].receive_ready_n      = 1'b1;
        pins_o[ch].transmit_ready_n     = 1'b0;
        pins_o[ch].irq                  = 1'b0;
        pins_o[ch].irq_oe               = 1'b0;
      end else begin
        pins_o[ch].tx = !regs_q[ch].line_ctl[`UCR_LCR_BREAK_BIT];
        pins_o[ch].general_output_two_n =
          !regs_q[ch].modem_ctl[`UCR_MCR_OP2_BIT];
        pins_o[ch].rts_n = !regs_q[ch].modem_ctl[`UCR_MCR_RTS_BIT];
        pins_o[ch].dtr_n = !regs_q[ch].modem_ctl[`UCR_MCR_DTR_BIT];
        pins_o[ch].receive_ready_n  = !regs_q[ch].rx_ready;
        pins_o[ch].transmit_ready_n = regs_q[ch].tx_pend;
        isr_v = isr_value(regs_q[ch]);
        // the pin asserts whenever the status shows something pending
        pins_o[ch].irq = !isr_v[`UCR_ISR_IDLE_BIT];
        // op2 gates the interrupt driver, so it floats until software acts
        pins_o[ch].irq_oe = regs_q[ch].modem_ctl[`UCR_MCR_OP2_BIT];
      end
    end
  end

endmodule : ucr_reset_bank
`default_nettype wire

// ==== tb/ucr_reset_bank_properties.sv ====
// concurrent checks of the channel bank reset state at its ports
`timescale 1ns/1ps
`default_nettype none
module ucr_reset_bank_properties #(
  parameter int NUM_CH = 2                             // channels
) (
  input wire logic                             clk_i,  // clock
  input wire logic                             rst_i,  // hardware reset
  input wire logic                             por_i,  // power-up reset
  input wire logic                             cyc_i,  // bus cycle
  input wire logic                             stb_i,  // bus strobe
  input wire logic                             we_i,   // bus write
  input wire logic [31:0]                      adr_i,  // byte address
  input wire logic [3:0]                       sel_i,  // byte enables
  input wire logic [31:0]                      dat_i,  // write data
  input wire logic [31:0]                      dat_o,  // read data
  input wire logic                             ack_o,  // acknowledge
  input wire ucr_pkg::ucr_link_s [NUM_CH-1:0]  link_i, // link inputs
  input wire ucr_pkg::ucr_pins_s [NUM_CH-1:0]  pins_o  // channel pins
);
  logic       fresh_q, fresh_d, rd_q, rd_d, ok_q, ok_d, rxv;
  logic [3:0] idx_q, idx_d;

  // fresh: no bus write and no received byte since the last reset
  always_comb begin
    rxv = 1'b0;
    for (int i = 0; i < NUM_CH; i++) rxv = rxv | link_i[i].rx_valid;
    rd_d    = cyc_i && stb_i && !ack_o && !we_i && !rst_i && !por_i;
    ok_d    = adr_i[31:7] == 25'h0000000;
    idx_d   = adr_i[5:2];
    fresh_d = rst_i || por_i || (fresh_q && !(cyc_i && stb_i && we_i) && !rxv);
  end

  always_ff @(posedge clk_i) begin
    fresh_q <= fresh_d;
    rd_q    <= rd_d;
    ok_q    <= ok_d;
    idx_q   <= idx_d;
  end

  function automatic logic idle(input ucr_pkg::ucr_pins_s p);
    return p.tx & p.general_output_two_n & p.rts_n & p.dtr_n &
           p.receive_ready_n & !p.transmit_ready_n & !p.irq_oe & !p.irq;
  endfunction : idle

  default clocking cb @(posedge clk_i); endclocking

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_fresh_rd;
    ack_o && rd_q && ok_q && fresh_q;
  endsequence
  property p_rst_val(i, v);
    disable iff (rst_i || por_i) s_fresh_rd ##0 idx_q == i |-> dat_o[7:0] == v;
  endproperty

  a_pins_reset: assert property ((rst_i || por_i) |-> idle(pins_o[0]) && idle(pins_o[NUM_CH-1]))
    else $error("pins not at reset levels during reset");
  a_pins_fresh: assert property (disable iff (rst_i || por_i) fresh_q |-> idle(pins_o[0]) && idle(pins_o[NUM_CH-1]))
    else $error("pins left reset levels untouched by software");
  a_ack_pulse: assert property (disable iff (rst_i || por_i) s_req |=> ack_o ##1 !ack_o)
    else $error("acknowledge not a one-cycle answer");
  a_ack_cause: assert property (disable iff (rst_i || por_i) ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("acknowledge without request");
  a_read_upper: assert property (disable iff (rst_i || por_i) ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_isr_reset: assert property (p_rst_val(4'h5, 8'h01))
    else $error("interrupt status wrong after reset");
  a_lsr_reset: assert property (p_rst_val(4'h8, 8'h60))
    else $error("line status wrong after reset");
  a_spr_reset: assert property (p_rst_val(4'hA, 8'hFF))
    else $error("scratch wrong after reset");
  a_flow_reset: assert property (disable iff (rst_i || por_i) s_fresh_rd ##0 idx_q[3:2] == 2'b11 |-> dat_o == 32'h00000000)
    else $error("flow character not cleared by reset");
  a_ctl_reset: assert property (disable iff (rst_i || por_i) s_fresh_rd ##0 idx_q inside {4'h2, 4'h4, 4'h6, 4'h7, 4'hB} |-> dat_o == 32'h00000000)
    else $error("control register not cleared by reset");
endmodule : ucr_reset_bank_properties

bind ucr_reset_bank ucr_reset_bank_properties #(.NUM_CH(NUM_CH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .link_i(link_i), .pins_o(pins_o));
`default_nettype wire

// ==== tb/ucr_link_model.sv ====
// far-side link model: received bytes, transmit completion, modem levels
`timescale 1ns/1ps
`default_nettype none
module ucr_link_model #(
  parameter int NUM_CH = 2                              // channels
) (
  input  wire logic                            clk_i,     // clock
  input  wire logic                            rst_i,     // any reset
  input  wire logic                            send_i,    // deliver a byte
  input  wire logic                            ch_i,      // its channel
  input  wire logic [7:0]                      byte_i,    // received byte
  input  wire logic [3:0]                      modem_n_i, // cd ri dsr cts
  input  wire logic [7:0]                      lag_i,     // transmit time
  input  wire ucr_pkg::ucr_pins_s [NUM_CH-1:0] pins_i,    // device pins
  output ucr_pkg::ucr_link_s [NUM_CH-1:0]      link_o     // link inputs
);
  logic [NUM_CH-1:0][7:0] cnt_q, cnt_d;
  logic [7:0]             pat_q, pat_d;

  always_comb begin
    pat_d = pat_q + 8'h01;
    for (int c = 0; c < NUM_CH; c++) begin
      cnt_d[c] = pins_i[c].transmit_ready_n ? cnt_q[c] + 8'h01 : 8'h00;
      link_o[c].rx_valid = send_i && (ch_i == c[0]);
      // data outside its strobe is a moving pattern, held at zero only during reset
      link_o[c].rx_data = link_o[c].rx_valid ? byte_i : pat_q;
      link_o[c].tx_done = pins_i[c].transmit_ready_n && cnt_q[c] == lag_i;
      {link_o[c].cd_n, link_o[c].ri_n, link_o[c].dsr_n, link_o[c].cts_n} =
        modem_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    cnt_q <= rst_i ? '0 : cnt_d;
    pat_q <= rst_i ? 8'h00 : pat_d;
  end
endmodule : ucr_link_model
`default_nettype wire

// ==== tb/ucr_reset_bank_tb.sv ====
// self-checking bench of the two-channel reset-state register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module ucr_reset_bank_tb;
  logic        clk_i = 1'b0;
  logic        rst_i, por_i, cyc, stb, we, send, sch;
  logic [31:0] adr, wdat, seed;
  logic [3:0]  sel, modem;
  logic [7:0]  sbyte, lag, rd;
  logic [7:0]  wv [2][16];
  int          fail_count, num_checks;
  wire logic [31:0]              dat_o;
  wire logic                     ack_o;
  wire ucr_pkg::ucr_link_s [1:0] link;
  wire ucr_pkg::ucr_pins_s [1:0] pins;

  always #12.5 clk_i = ~clk_i;

  ucr_reset_bank #(.NUM_CH(2)) u_ucr_reset_bank (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
    .ack_o(ack_o), .link_i(link), .pins_o(pins));
  ucr_link_model #(.NUM_CH(2)) u_ucr_link_model (
    .clk_i(clk_i), .rst_i(rst_i || por_i), .send_i(send), .ch_i(sch),
    .byte_i(sbyte), .modem_n_i(modem), .lag_i(lag), .pins_i(pins),
    .link_o(link));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] exp_rst(input logic [3:0] i,
      input logic [7:0] dh, input logic [7:0] dl, input logic [3:0] m);
    case (i)
      4'h0: return dh;
      4'h1: return dl;
      4'h5: return 8'h01;
      4'h8: return 8'h60;
      4'h9: return {~m, 4'h0};
      4'hA: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : exp_rst

  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // bit 4 of the index reaches address bit 7, outside the map
  task automatic wb(input logic w, input logic c, input logic [4:0] i,
      input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {24'h000000, i[4], c, i[3:0], 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) begin
      fail_count++;
      conclude();
    end
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic chk_pins();
    logic [7:0] pv;
    for (int c = 0; c < 2; c++) begin
      pv = {pins[c].tx, pins[c].general_output_two_n, pins[c].rts_n,
            pins[c].dtr_n, pins[c].receive_ready_n,
            pins[c].transmit_ready_n, pins[c].irq_oe, pins[c].irq};
      `CHK("pins", 8'hF8, pv)
    end
  endtask : chk_pins

  // keep: divisors hold what software wrote, as after a hardware reset
  task automatic check_rst(input logic keep);
    logic [7:0] dh, dl;
    for (int c = 0; c < 2; c++) begin
      dh = keep ? wv[c][0] : 8'h00;
      dl = keep ? wv[c][1] : 8'h01;
      for (int i = 0; i < 16; i++) begin
        if (i != 3) begin
          wb(1'b0, c[0], i[4:0], 8'h00);
          `CHK("reset value", exp_rst(i[3:0], dh, dl, modem), rd)
        end
      end
    end
  endtask : check_rst

  initial begin
    fail_count = 0;
    num_checks = 0;
    seed = xs(32'h0000D8CC);
    rst_i = 1'b1;
    por_i = 1'b1;
    {cyc, stb, we, send, sch} = 5'h00;
    adr = 32'h00000000;
    wdat = 32'h00000000;
    sel = 4'h0;
    sbyte = 8'h00;
    lag = 8'h00;
    modem = seed[3:0];
    repeat (16) @(posedge clk_i);
    chk_pins();
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    chk_pins();
    check_rst(1'b0);
    for (int c = 0; c < 2; c++) begin
      lag <= c ? 8'hF0 : 8'h00;
      wb(1'b1, c[0], 5'h0B, 8'h10);
      for (int i = 0; i < 16; i++) begin
        if (!(i inside {8, 9, 11})) begin
          seed = xs(seed);
          wv[c][i] = seed[7:0];
          wb(1'b1, c[0], i[4:0], seed[7:0]);
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 16; i++) begin
        if (i inside {0, 1, 2, 4, 6, 7, 10, 12, 13, 14, 15}) begin
          wb(1'b0, c[0], i[4:0], 8'h00);
          `CHK("readback", wv[c][i], rd)
        end
      end
    end
    send <= 1'b1;
    sbyte <= seed[15:8];
    @(posedge clk_i);
    send <= 1'b0;
    modem <= ~modem;
    repeat (3) @(posedge clk_i);
    // hardware reset while a transmit is still pending on channel 1
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_pins();
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_pins();
    check_rst(1'b1);
    wb(1'b1, 1'b0, 5'h1A, 8'h00);
    wb(1'b0, 1'b0, 5'h0A, 8'h00);
    `CHK("scratch", 8'hFF, rd)
    wb(1'b0, 1'b0, 5'h1A, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    por_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_pins();
    por_i <= 1'b0;
    @(posedge clk_i);
    chk_pins();
    check_rst(1'b0);
    conclude();
  end
endmodule : ucr_reset_bank_tb
`default_nettype wire
